// *** design/alu_core.sv ***
// Purpose: executes one command per write, holds accumulator, flags, pointers, file memory
// Assumes: AXI4-Lite slave, one outstanding write and read, synchronous active-low reset
// Notes: pointer reaches file memory through its low seven bits only
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module alu_core
  import alu_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) m[8*i +: 8] = nw[8*i +: 8];
    end
    return m;
  endfunction

  // wraps modulo the full 16-bit space
  function automatic logic [15:0] ptr_add(input logic [15:0] p, input logic [15:0] d);
    return p + d;
  endfunction

  logic [7:0] mem [MEM_DEPTH];
  logic awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt, wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [11:0] awaddr_r, awaddr_nxt;
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic c_r, c_nxt, z_r, z_nxt;
  logic [15:0] ptr0_r, ptr0_nxt, ptr1_r, ptr1_nxt, eaddr_r, eaddr_nxt;
  logic [31:0] cmd_r, cmd_nxt;
  logic aw_take, w_take, ar_take, do_wr, exec, wr_hit;
  logic mem_we;
  logic [6:0] mem_wa;
  logic [7:0] mem_wd;
  logic [2:0] op;
  logic dest, n_sel, ofs;
  logic [1:0] pointer_update_mode;
  logic [6:0] f_addr, fa;
  logic [15:0] base, ea, new_ptr, k_ext;
  logic [7:0] fval, ind_val, alu_in, alu_res;
  logic alu_c, alu_z;

  assign aw_take = awvalid && awready_r;
  assign w_take = wvalid && wready_r;
  assign ar_take = arvalid && arready_r;
  assign do_wr = aw_have_r && w_have_r && !bvalid_r;
  assign exec = do_wr && (awaddr_r == ADDR_CMD);

  // command fields from the word being written
  assign op = wdata_r[CMD_OP_LSB +: 3];
  assign f_addr = wdata_r[CMD_F_LSB +: 7];
  assign n_sel = wdata_r[CMD_N];
  assign pointer_update_mode = wdata_r[CMD_UPD_LSB +: 2];
  assign ofs = wdata_r[CMD_OFS];
  assign k_ext = {{10{wdata_r[CMD_K_LSB + 5]}}, wdata_r[CMD_K_LSB +: 6]};
  // omitted destination on a shift defaults to the file register
  assign dest = wdata_r[CMD_DEST] ||
                (wdata_r[CMD_DEF] && (op == OP_LSL || op == OP_LSR));

  // alias addresses resolve to the pointer target, no storage of their own
  assign fa = (f_addr == ALIAS0) ? ptr0_r[6:0] :
              (f_addr == ALIAS1) ? ptr1_r[6:0] : f_addr;
  assign fval = mem[fa];

  always_comb begin
    base = n_sel ? ptr1_r : ptr0_r;
    ea = base;
    new_ptr = base;
    if (ofs) begin
      ea = ptr_add(base, k_ext);
    end else begin
      unique case (pointer_update_mode)
        UPD_PRE_INC: begin
          ea = ptr_add(base, PTR_ONE);
          new_ptr = ea;
        end
        UPD_PRE_DEC: begin
          ea = ptr_add(base, PTR_MINUS_ONE);
          new_ptr = ea;
        end
        UPD_POST_INC: new_ptr = ptr_add(base, PTR_ONE);
        UPD_POST_DEC: new_ptr = ptr_add(base, PTR_MINUS_ONE);
      endcase
    end
  end

  assign ind_val = mem[ea[6:0]];
  assign alu_in = (op == OP_IND) ? ind_val : fval;

  alu_unit u_alu (
    .op(op),
    .acc(acc_r),
    .data(alu_in),
    .c_in(c_r),
    .res(alu_res),
    .c_out(alu_c),
    .z_out(alu_z)
  );

  // bus channel handshakes
  always_comb begin
    aw_have_nxt = do_wr ? 1'b0 : (aw_have_r || aw_take);
    w_have_nxt = do_wr ? 1'b0 : (w_have_r || w_take);
    awaddr_nxt = aw_take ? {awaddr[11:2], 2'b00} : awaddr_r;
    wdata_nxt = w_take ? wdata : wdata_r;
    wstrb_nxt = w_take ? wstrb : wstrb_r;
    bvalid_nxt = do_wr ? 1'b1 : ((bvalid_r && bready) ? 1'b0 : bvalid_r);
    bresp_nxt = do_wr ? (wr_hit ? RESP_OKAY : RESP_SLVERR) : bresp_r;
    awready_nxt = !aw_have_nxt && !bvalid_nxt;
    wready_nxt = !w_have_nxt && !bvalid_nxt;
    rvalid_nxt = ar_take ? 1'b1 : ((rvalid_r && rready) ? 1'b0 : rvalid_r);
    arready_nxt = !rvalid_nxt;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (ar_take) begin
      rresp_nxt = RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (araddr[11:9] == MEM_WINDOW) rdata_nxt = {24'h00_0000, mem[araddr[8:2]]};
      else begin
        unique case ({araddr[11:2], 2'b00})
          ADDR_ACC: rdata_nxt = {24'h00_0000, acc_r};
          ADDR_STATUS: rdata_nxt = {30'h0000_0000, z_r, c_r};
          ADDR_PTR0: rdata_nxt = {16'h0000, ptr0_r};
          ADDR_PTR1: rdata_nxt = {16'h0000, ptr1_r};
          ADDR_CMD: rdata_nxt = cmd_r;
          ADDR_EADDR: rdata_nxt = {16'h0000, eaddr_r};
          default: rresp_nxt = RESP_SLVERR;
        endcase
      end
    end
  end

  // register writes and command execution
  always_comb begin
    acc_nxt = acc_r;
    c_nxt = c_r;
    z_nxt = z_r;
    ptr0_nxt = ptr0_r;
    ptr1_nxt = ptr1_r;
    cmd_nxt = cmd_r;
    eaddr_nxt = eaddr_r;
    mem_we = 1'b0;
    mem_wa = fa;
    mem_wd = alu_res;
    wr_hit = 1'b1;
    if (do_wr) begin
      if (awaddr_r[11:9] == MEM_WINDOW) begin
        mem_we = wstrb_r[0];
        mem_wa = awaddr_r[8:2];
        mem_wd = wdata_r[7:0];
      end else begin
        unique case (awaddr_r)
          ADDR_ACC: acc_nxt = 8'(merge({24'h00_0000, acc_r}, wdata_r, wstrb_r));
          ADDR_STATUS: begin
            if (wstrb_r[0]) begin
              c_nxt = wdata_r[STAT_C];
              z_nxt = wdata_r[STAT_Z];
            end
          end
          ADDR_PTR0: ptr0_nxt = 16'(merge({16'h0000, ptr0_r}, wdata_r, wstrb_r));
          ADDR_PTR1: ptr1_nxt = 16'(merge({16'h0000, ptr1_r}, wdata_r, wstrb_r));
          ADDR_CMD: cmd_nxt = merge(cmd_r, wdata_r, wstrb_r);
          default: wr_hit = 1'b0;
        endcase
      end
    end
    if (exec) begin
      // one write executes one instruction in the same cycle
      unique case (op)
        OP_OR, OP_MOV, OP_LSL, OP_LSR: begin
          z_nxt = alu_z;
          if (op == OP_LSL || op == OP_LSR) c_nxt = alu_c;
          eaddr_nxt = {9'h000, fa};
          if (dest) mem_we = 1'b1;
          else acc_nxt = alu_res;
        end
        OP_IND: begin
          acc_nxt = alu_res;
          z_nxt = alu_z;
          eaddr_nxt = ea;
          if (n_sel) ptr1_nxt = new_ptr;
          else ptr0_nxt = new_ptr;
        end
        default: eaddr_nxt = eaddr_r;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (mem_we) mem[mem_wa] <= mem_wd;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      arready_r <= 1'b1;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      awaddr_r <= 12'h000;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      acc_r <= ACC_RST;
      c_r <= 1'b0;
      z_r <= 1'b0;
      ptr0_r <= PTR_RST;
      ptr1_r <= PTR_RST;
      cmd_r <= CMD_RST;
      eaddr_r <= PTR_RST;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      bvalid_r <= bvalid_nxt;
      rvalid_r <= rvalid_nxt;
      bresp_r <= bresp_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      awaddr_r <= awaddr_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      acc_r <= acc_nxt;
      c_r <= c_nxt;
      z_r <= z_nxt;
      ptr0_r <= ptr0_nxt;
      ptr1_r <= ptr1_nxt;
      cmd_r <= cmd_nxt;
      eaddr_r <= eaddr_nxt;
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_file_op;
    exec && (op inside {OP_OR, OP_LSL, OP_LSR, OP_MOV});
  endsequence
  sequence s_ind(logic sel, logic [1:0] mode);
    exec && op == OP_IND && !ofs && n_sel == sel && pointer_update_mode == mode;
  endsequence

  property p_or_zero;
    exec && op == OP_OR |=> z_r == ($past(acc_r | fval) == 8'h00) && $stable(c_r);
  endproperty
  a_or_zero: assert property (p_or_zero) else $error("or zero flag wrong");
  property p_dest_file;
    s_file_op ##0 dest |=> $stable(acc_r) ##1 $stable(acc_r) || bvalid_r;
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file dest touched acc");
  property p_lsl;
    exec && op == OP_LSL |=> c_r == $past(fval[7]) && z_r == ($past(fval[6:0]) == 7'h00);
  endproperty
  a_lsl: assert property (p_lsl) else $error("left shift flags wrong");
  property p_lsr;
    exec && op == OP_LSR |=> c_r == $past(fval[0]) && z_r == ($past(fval[7:1]) == 7'h00);
  endproperty
  a_lsr: assert property (p_lsr) else $error("right shift flags wrong");
  property p_mov;
    exec && op == OP_MOV && !dest |=> acc_r == $past(fval) && z_r == (acc_r == 8'h00);
  endproperty
  a_mov: assert property (p_mov) else $error("move result wrong");
  property p_ind_load;
    exec && op == OP_IND |=> acc_r == $past(ind_val) && $stable(c_r) && bvalid_r;
  endproperty
  a_ind_load: assert property (p_ind_load) else $error("indirect load wrong");
  property p_post_inc;
    s_ind(1'b0, UPD_POST_INC) |=> eaddr_r == $past(ptr0_r) && ptr0_r == $past(ptr0_r) + 16'h0001;
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("post increment wrong");
  property p_pre_dec;
    s_ind(1'b1, UPD_PRE_DEC) |=> eaddr_r == ptr1_r && ptr1_r == $past(ptr1_r) - 16'h0001;
  endproperty
  a_pre_dec: assert property (p_pre_dec) else $error("pre decrement wrong");
  property p_offset;
    exec && op == OP_IND && ofs |=> $stable(ptr0_r) && $stable(ptr1_r);
  endproperty
  a_offset: assert property (p_offset) else $error("offset moved pointer");
  property p_wrap;
    s_ind(1'b0, UPD_PRE_INC) ##0 ptr0_r == 16'hFFFF |=> ptr0_r == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");
endmodule
`default_nettype wire

// *** design/alu_pkg.sv ***
// Purpose: constants and types for the accumulator alu, shifter and indirect-load block
// Assumes: one 250 MHz clock, 32-bit AXI4-Lite register access
// Notes: command word layout and register offsets shared by core and alu
// Behaviour
// - or_acc_into_file ORs accumulator with 7-bit addressed file, updates only zero.
// - destination bit zero sends result to accumulator, one back to file.
// - left shift: bit 7 to carry, zero into bit 0, carry and zero updated.
// - right shift: bit 0 to carry, zero into bit 7, carry and zero updated.
// - file_move_test copies file to destination, zero flag from value, single cycle.
// - indirect load reads via pointer chosen by index, to accumulator, updates zero.
// - pointer_update_mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - pre modes access pointer plus/minus one; post modes access original then adjust.
// - offset mode accesses pointer plus signed -32..31, pointer left unchanged.
// - alias file addresses have no storage; they reach the pointer's target.
// - pointers are 16 bits and wrap modulo 65536 on increment or decrement.
// - pointer adjustment never touches status flags; only data alters zero.
`default_nettype none
package alu_pkg;
  localparam logic [11:0] ADDR_ACC = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_PTR0 = 12'h008;
  localparam logic [11:0] ADDR_PTR1 = 12'h00C;
  localparam logic [11:0] ADDR_CMD = 12'h010;
  localparam logic [11:0] ADDR_EADDR = 12'h014;
  localparam logic [2:0] MEM_WINDOW = 3'h1;
  localparam int MEM_DEPTH = 128;
  localparam int STAT_C = 0;
  localparam int STAT_Z = 1;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DEST = 3;
  localparam int CMD_F_LSB = 4;
  localparam int CMD_N = 11;
  localparam int CMD_UPD_LSB = 12;
  localparam int CMD_OFS = 14;
  localparam int CMD_K_LSB = 15;
  localparam int CMD_DEF = 21;
  localparam logic [6:0] ALIAS0 = 7'h00;
  localparam logic [6:0] ALIAS1 = 7'h01;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [31:0] CMD_RST = 32'h0000_0000;
  localparam logic [15:0] PTR_ONE = 16'h0001;
  localparam logic [15:0] PTR_MINUS_ONE = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_OR = 3'h0,
    OP_LSL = 3'h1,
    OP_LSR = 3'h2,
    OP_MOV = 3'h3,
    OP_IND = 3'h4
  } op_type;

  typedef enum logic [1:0] {
    UPD_PRE_INC = 2'h0,
    UPD_PRE_DEC = 2'h1,
    UPD_POST_INC = 2'h2,
    UPD_POST_DEC = 2'h3
  } upd_mode_type;
endpackage
`default_nettype wire

// *** design/alu_unit.sv ***
// Purpose: byte result, carry and zero for or, shifts, moves and indirect load
// Assumes: purely combinational, flags chosen by the caller per operation
// Notes: data input is the file value, or the indirect byte for the load
`timescale 1ns/1ps
`default_nettype none
module alu_unit
  import alu_pkg::*;
(
  input wire logic [2:0] op,
  input wire logic [7:0] acc,
  input wire logic [7:0] data,
  input wire logic c_in,
  output logic [7:0] res,
  output logic c_out,
  output logic z_out
);
  always_comb begin
    res = data;
    c_out = c_in;
    unique case (op)
      OP_OR: res = acc | data;
      OP_LSL: begin
        res = {data[6:0], 1'b0};
        c_out = data[7];
      end
      OP_LSR: begin
        res = {1'b0, data[7:1]};
        c_out = data[0];
      end
      default: res = data;
    endcase
    z_out = (res == 8'h00);
  end
endmodule
`default_nettype wire

// *** verif/alu_shift_and_indirect_move_bench.sv ***
// Purpose: self-checking bench for alu_core over AXI4-Lite
// Assumes: bready and rready held high, full strobes, file memory written before use
// Notes: expectations computed here from the command fields, never read back first
`timescale 1ns/1ps
`default_nettype none
module alu_shift_and_indirect_move_bench;
  import alu_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int wlat;

  alu_core dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic final_report();
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // generous ceiling: the whole run needs about a thousand cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        break;
      end
    end
    wlat = n;
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    d = 32'h0;
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    chk(d, exp);
  endtask

  function automatic logic [11:0] ma(input logic [6:0] idx);
    ma = 12'h200 + {3'h0, idx, 2'b00};
  endfunction

  function automatic logic [31:0] mk(input logic [2:0] op, input logic dest,
      input logic [6:0] f, input logic n, input logic [1:0] upd, input logic ofs,
      input logic [5:0] k, input logic def);
    mk = 32'h0;
    mk[CMD_OP_LSB+:3] = op;
    mk[CMD_DEST] = dest;
    mk[CMD_F_LSB+:7] = f;
    mk[CMD_N] = n;
    mk[CMD_UPD_LSB+:2] = upd;
    mk[CMD_OFS] = ofs;
    mk[CMD_K_LSB+:6] = k;
    mk[CMD_DEF] = def;
  endfunction

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rd(ADDR_ACC, 32'h0);
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_PTR0, 32'h0);
    rd(ADDR_PTR1, 32'h0);
    axr(12'h100, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(d, 32'h0);
    axw(12'h100, 32'h0000_00FF, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    // opcode 5 is stored but executes nothing
    wr(ADDR_CMD, 32'h0000_0005);
    rd(ADDR_CMD, 32'h0000_0005);
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_EADDR, 32'h0);
    rd(ADDR_ACC, 32'h0);
  endtask

  task automatic t_or();
    wr(ma(7'h05), 32'h0C);
    wr(ADDR_ACC, 32'h30);
    wr(ADDR_STATUS, 32'h1);
    wr(ADDR_CMD, mk(OP_OR, 1'b0, 7'h05, 1'b0, 2'h0, 1'b0, 6'h0, 1'b0));
    rd(ADDR_ACC, 32'h3C);
    rd(ADDR_STATUS, 32'h1);
    rd(ma(7'h05), 32'h0C);
    wr(ADDR_ACC, 32'h0);
    wr(ma(7'h06), 32'h0);
    wr(ADDR_CMD, mk(OP_OR, 1'b1, 7'h06, 1'b0, 2'h0, 1'b0, 6'h0, 1'b0));
    rd(ADDR_STATUS, 32'h3);
    wr(ma(7'h06), 32'h11);
    wr(ADDR_ACC, 32'h22);
    wr(ADDR_CMD, mk(OP_OR, 1'b1, 7'h06, 1'b0, 2'h0, 1'b0, 6'h0, 1'b0));
    rd(ma(7'h06), 32'h33);
    rd(ADDR_ACC, 32'h22);
  endtask

  task automatic t_shift();
    wr(ADDR_STATUS, 32'h0);
    wr(ma(7'h07), 32'h81);
    wr(ADDR_CMD, mk(OP_LSL, 1'b0, 7'h07, 1'b0, 2'h0, 1'b0, 6'h0, 1'b0));
    rd(ADDR_ACC, 32'h02);
    rd(ADDR_STATUS, 32'h1);
    wr(ADDR_CMD, mk(OP_LSR, 1'b0, 7'h07, 1'b0, 2'h0, 1'b0, 6'h0, 1'b0));
    rd(ADDR_ACC, 32'h40);
    rd(ADDR_STATUS, 32'h1);
    wr(ma(7'h08), 32'h01);
    wr(ADDR_CMD, mk(OP_LSR, 1'b1, 7'h08, 1'b0, 2'h0, 1'b0, 6'h0, 1'b0));
    rd(ma(7'h08), 32'h00);
    rd(ADDR_STATUS, 32'h3);
    wr(ma(7'h09), 32'h40);
    wr(ADDR_CMD, mk(OP_LSL, 1'b0, 7'h09, 1'b0, 2'h0, 1'b0, 6'h0, 1'b1));
    rd(ma(7'h09), 32'h80);
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_ACC, 32'h40);
  endtask

  task automatic t_move();
    wr(ADDR_STATUS, 32'h1);
    wr(ma(7'h0A), 32'h00);
    wr(ADDR_CMD, mk(OP_MOV, 1'b1, 7'h0A, 1'b0, 2'h0, 1'b0, 6'h0, 1'b0));
    chk(wlat, 32'd3);
    rd(ADDR_STATUS, 32'h3);
    wr(ma(7'h0B), 32'hA5);
    wr(ADDR_CMD, mk(OP_MOV, 1'b0, 7'h0B, 1'b0, 2'h0, 1'b0, 6'h0, 1'b0));
    rd(ADDR_ACC, 32'hA5);
    rd(ADDR_STATUS, 32'h1);
  endtask

  // memory holds index xor 10h, so index 10h reads as zero
  task automatic ind_one(input logic n, input logic [15:0] base, input logic [1:0] upd,
      input logic ofs, input logic [5:0] k);
    logic [15:0] ea, np;
    logic [7:0] v;
    ea = (upd == UPD_PRE_INC) ? base + PTR_ONE :
         (upd == UPD_PRE_DEC) ? base + PTR_MINUS_ONE : base;
    np = upd[0] ? base + PTR_MINUS_ONE : base + PTR_ONE;
    if (ofs) begin
      ea = base + {{10{k[5]}}, k};
      np = base;
    end
    v = {1'b0, ea[6:0]} ^ 8'h10;
    wr(ADDR_PTR0, 32'h0000_0100);
    wr(ADDR_PTR1, 32'h0000_0100);
    wr(n ? ADDR_PTR1 : ADDR_PTR0, {16'h0, base});
    wr(ADDR_STATUS, 32'h1);
    wr(ADDR_CMD, mk(OP_IND, 1'b0, 7'h0, n, upd, ofs, k, 1'b0));
    rd(ADDR_ACC, {24'h0, v});
    rd(ADDR_STATUS, {30'h0, v == 8'h0, 1'b1});
    rd(n ? ADDR_PTR1 : ADDR_PTR0, {16'h0, np});
    rd(ADDR_EADDR, {16'h0, ea});
    rd(n ? ADDR_PTR0 : ADDR_PTR1, 32'h0000_0100);
  endtask

  task automatic t_indirect();
    for (int i = 0; i < MEM_DEPTH; i++) begin
      wr(ma(i[6:0]), {24'h0, i[7:0] ^ 8'h10});
    end
    for (int m = 0; m < 4; m++) begin
      ind_one(1'b1, 16'h0010, m[1:0], 1'b0, 6'h0);
      ind_one(1'b0, 16'h0011, m[1:0], 1'b0, 6'h0);
    end
    ind_one(1'b0, 16'hFFFF, UPD_POST_INC, 1'b0, 6'h0);
    ind_one(1'b1, 16'hFFFF, UPD_PRE_INC, 1'b0, 6'h0);
    ind_one(1'b0, 16'hFFFF, UPD_PRE_INC, 1'b0, 6'h0);
    ind_one(1'b0, 16'h0000, UPD_PRE_DEC, 1'b0, 6'h0);
    ind_one(1'b1, 16'h0000, UPD_POST_DEC, 1'b0, 6'h0);
    ind_one(1'b0, 16'h0030, UPD_POST_INC, 1'b1, 6'h20);
    ind_one(1'b1, 16'h0010, UPD_PRE_DEC, 1'b1, 6'h1F);
    ind_one(1'b1, 16'h0020, UPD_POST_DEC, 1'b1, 6'h30);
  endtask

  task automatic t_alias();
    wr(ADDR_PTR0, 32'h0000_0033);
    wr(ADDR_PTR1, 32'h0000_0044);
    wr(ADDR_CMD, mk(OP_MOV, 1'b0, ALIAS0, 1'b0, 2'h0, 1'b0, 6'h0, 1'b0));
    rd(ADDR_ACC, 32'h23);
    wr(ADDR_ACC, 32'h80);
    wr(ADDR_CMD, mk(OP_OR, 1'b1, ALIAS1, 1'b0, 2'h0, 1'b0, 6'h0, 1'b0));
    rd(ma(7'h44), 32'hD4);
    rd(ADDR_EADDR, 32'h0000_0044);
    rd(ADDR_PTR1, 32'h0000_0044);
  endtask

  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hF;
    bready = 1'b1;
    rready = 1'b1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_or();
    t_shift();
    t_move();
    t_indirect();
    t_alias();
    final_report();
  end
endmodule
`default_nettype wire
